// File: inc/periodic_timer_pkg.sv
package periodic_timer_pkg;

  // Widths.
  localparam int CNT_W = 10;
  localparam int ADDR_W = 8;

  // Register byte addresses, one aligned word each.
  localparam logic [ADDR_W-1:0] OFS_CTL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTL2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMPA_LO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CMPA_HI = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CAPB_LO = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CAPB_HI = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PER_LO = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_PER_HI = 8'h28;

  // Field positions of timer_control_0.
  localparam int C0_PAUSE = 7;
  localparam int C0_CLK_LSB = 4;
  localparam int C0_RUN = 3;
  localparam logic [7:0] C0_MASK = 8'hF8;

  // Field positions of timer_control_1.
  localparam int C1_OP_LSB = 6;
  localparam int C1_IO_LSB = 4;
  localparam int C1_OC = 3;
  localparam int C1_INV = 2;
  localparam int C1_CAPS = 1;
  localparam int C1_CCLR = 0;

  // Field positions of timer_capture_control.
  localparam int C2_TCLR_LSB = 1;
  localparam int C2_VLF = 0;

  // Reset values.
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [1:0] TCLR_RST = 2'h0;
  localparam logic [CNT_W-1:0] VAL_RST = 10'h000;

  // Clock divider counts.
  localparam int SYS_DIV = 4;
  localparam int HI_DIV_A = 16;
  localparam int HI_DIV_B = 64;

  typedef enum logic [1:0] {
    OP_CMP = 2'h0,
    OP_CAP = 2'h1,
    OP_PWM = 2'h2,
    OP_TMR = 2'h3
  } op_e;

  typedef enum logic [2:0] {
    CK_SYS4 = 3'h0,
    CK_SYS = 3'h1,
    CK_HI16 = 3'h2,
    CK_HI64 = 3'h3,
    CK_SUB_A = 3'h4,
    CK_SUB_B = 3'h5,
    CK_EXT_R = 3'h6,
    CK_EXT_F = 3'h7
  } clk_e;

endpackage

// File: inc/pin_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pin_edge_if;
  logic rise;
  logic fall;
  logic level;
  modport src (output rise, output fall, output level);
  modport dst (input rise, input fall, input level);
endinterface
`default_nettype wire

// File: src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Asynchronous pin.
  input wire logic pin,
  // Filtered level and edges.
  pin_edge_if.src e
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  // A change is accepted once the second and third stages agree.
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign e.rise = st_q.s2 & st_q.s3 & ~st_q.lvl;
  assign e.fall = ~st_q.s2 & ~st_q.s3 & st_q.lvl;
  assign e.level = st_q.lvl;
endmodule
`default_nettype wire

// File: src/tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tick_gen (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Source selection.
  input wire periodic_timer_pkg::clk_e clk_sel,
  // Synchronised clock pins.
  pin_edge_if.dst hi,
  pin_edge_if.dst sub,
  pin_edge_if.dst ext,
  // One-cycle count pulse.
  output logic tick
);
  import periodic_timer_pkg::*;

  typedef struct packed {
    logic [1:0] div;
    logic [5:0] hdiv;
  } tick_s;

  tick_s st_q;
  tick_s st_d;

  // Prescalers for the system clock and the high-speed clock.
  always_comb begin
    st_d = st_q;
    st_d.div = st_q.div + 2'h1;
    if (hi.rise) begin
      st_d.hdiv = st_q.hdiv + 6'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Counter clock source selection.
  always_comb begin
    case (clk_sel)
      CK_SYS4: tick = (st_q.div == 2'(SYS_DIV - 1));
      CK_SYS: tick = 1'b1;
      CK_HI16: tick = hi.rise & (st_q.hdiv[3:0] == 4'(HI_DIV_A - 1));
      CK_HI64: tick = hi.rise & (st_q.hdiv == 6'(HI_DIV_B - 1));
      CK_SUB_A: tick = sub.rise;
      CK_SUB_B: tick = sub.rise;
      CK_EXT_R: tick = ext.rise;
      CK_EXT_F: tick = ext.fall;
      default: tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// File: src/periodic_timer.sv
`timescale 1ns/1ps
`default_nettype none
module periodic_timer #(
  parameter bit HAS_CAP_B = 1'b1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [periodic_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins and internal sources.
  input wire logic ext_clk_pin,
  input wire logic cap_input_pin,
  input wire logic line_cmp_out,
  input wire logic high_clk,
  input wire logic sub_clk,
  input wire logic [1:0] input_src_field,
  // Timer output and match events.
  output logic timer_out_pin,
  output logic timer_out_active,
  output logic cmp_a_flag,
  output logic cmp_p_flag
);
  import periodic_timer_pkg::*;

  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [1:0] tclr;
    logic vlf;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cap_b;
    logic [CNT_W-1:0] cmp_p;
    logic run_prev;
    logic out_raw;
    logic pin;
    logic pin_act;
    logic a_flag;
    logic p_flag;
    logic [31:0] rdata;
    logic err;
  } tmr_s;

  tmr_s st_q;
  tmr_s st_d;

  pin_edge_if ext_e ();
  pin_edge_if cap_e ();
  pin_edge_if line_e ();
  pin_edge_if hi_e ();
  pin_edge_if sub_e ();

  logic tick;

  // Every pin passes a three-stage synchroniser and edge filter.
  pin_sync u_ext (.sys_clk(sys_clk), .nrst(nrst), .pin(ext_clk_pin), .e(ext_e));
  pin_sync u_cap (.sys_clk(sys_clk), .nrst(nrst), .pin(cap_input_pin), .e(cap_e));
  pin_sync u_line (.sys_clk(sys_clk), .nrst(nrst), .pin(line_cmp_out), .e(line_e));
  pin_sync u_hi (.sys_clk(sys_clk), .nrst(nrst), .pin(high_clk), .e(hi_e));
  pin_sync u_sub (.sys_clk(sys_clk), .nrst(nrst), .pin(sub_clk), .e(sub_e));

  tick_gen u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_sel(clk_e'(st_q.ctl0[C0_CLK_LSB +: 3])),
    .hi(hi_e),
    .sub(sub_e),
    .ext(ext_e),
    .tick(tick)
  );

  // Replaces the low byte of a ten-bit value.
  function automatic logic [CNT_W-1:0] put_lo(input logic [CNT_W-1:0] v, input logic [7:0] b);
    put_lo = {v[CNT_W-1:8], b};
  endfunction

  // Replaces the two high bits of a ten-bit value.
  function automatic logic [CNT_W-1:0] put_hi(input logic [CNT_W-1:0] v, input logic [7:0] b);
    put_hi = {b[1:0], v[7:0]};
  endfunction

  // Places a register byte in the low lane of a bus word.
  function automatic logic [31:0] word8(input logic [7:0] b);
    word8 = {24'h000000, b};
  endfunction

  logic run;
  logic pause;
  op_e op;
  logic [1:0] io;
  logic oc;
  logic inv;
  logic caps;
  logic cclr;
  logic run_rise;
  logic adv;
  logic [CNT_W:0] nxt;
  logic a_hit;
  logic p_hit;
  logic trig_rise;
  logic trig_fall;
  logic src_level_rise;
  logic src_level_fall;
  logic cap_rise;
  logic cap_fall;
  logic edge_clr;
  logic clr;
  logic setup;
  logic access;
  logic unmapped;

  always_comb begin
    st_d = st_q;
    st_d.a_flag = 1'b0;
    st_d.p_flag = 1'b0;

    run = st_q.ctl0[C0_RUN];
    pause = st_q.ctl0[C0_PAUSE];
    op = op_e'(st_q.ctl1[C1_OP_LSB +: 2]);
    io = st_q.ctl1[C1_IO_LSB +: 2];
    oc = st_q.ctl1[C1_OC];
    inv = st_q.ctl1[C1_INV];
    caps = st_q.ctl1[C1_CAPS];
    cclr = st_q.ctl1[C1_CCLR];

    // Switch-on edge and counting enable.
    run_rise = run & ~st_q.run_prev;
    st_d.run_prev = run;
    adv = run & ~pause & tick;

    // Comparators see the value the counter is about to take.
    nxt = {1'b0, st_q.cnt} + 11'h001;
    a_hit = adv & (nxt[CNT_W-1:0] == st_q.cmp_a) & (st_q.cmp_a != VAL_RST);
    p_hit = adv & (nxt[CNT_W-1:0] == st_q.cmp_p);

    // Capture trigger source.
    if (HAS_CAP_B && input_src_field != 2'h0) begin
      src_level_rise = line_e.rise;
      src_level_fall = line_e.fall;
    end else begin
      src_level_rise = cap_e.rise;
      src_level_fall = cap_e.fall;
    end
    trig_rise = caps ? ext_e.rise : src_level_rise;
    trig_fall = caps ? ext_e.fall : src_level_fall;

    // Edge selection for capture.
    cap_rise = 1'b0;
    cap_fall = 1'b0;
    edge_clr = 1'b0;
    if (op == OP_CAP && run) begin
      cap_rise = trig_rise & ((io == 2'h0) | (io == 2'h2));
      cap_fall = trig_fall & ((io == 2'h1) | (io == 2'h2));
      // Extra clear on trigger edges.
      if (HAS_CAP_B) begin
        case (st_q.tclr)
          2'h1: edge_clr = trig_rise;
          2'h2: edge_clr = trig_fall;
          2'h3: edge_clr = trig_rise | trig_fall;
          default: edge_clr = 1'b0;
        endcase
      end
    end

    // Clear condition and match requests per mode.
    case (op)
      OP_CMP, OP_TMR: begin
        // Overflow wraps to zero when the period value is zero.
        clr = cclr ? a_hit : p_hit;
        st_d.a_flag = a_hit;
        st_d.p_flag = p_hit & ~cclr;
      end
      OP_PWM: begin
        clr = p_hit;
        st_d.a_flag = a_hit;
        st_d.p_flag = p_hit;
      end
      OP_CAP: begin
        clr = p_hit;
        st_d.a_flag = cap_rise | cap_fall;
        st_d.p_flag = p_hit;
      end
      default: begin
        clr = 1'b0;
      end
    endcase

    // Up counter: only a switch-on, a clear or a tick changes it.
    if (run_rise) begin
      st_d.cnt = VAL_RST;
    end else if (edge_clr) begin
      st_d.cnt = VAL_RST;
    end else if (adv) begin
      st_d.cnt = clr ? VAL_RST : nxt[CNT_W-1:0];
    end

    // Output waveform.
    if (run_rise && (op != OP_TMR) && (op != OP_CAP)) begin
      st_d.out_raw = oc;
    end else if (op == OP_CMP) begin
      // Only comparator A acts on the output.
      if (a_hit) begin
        case (io)
          2'h1: st_d.out_raw = 1'b0;
          2'h2: st_d.out_raw = 1'b1;
          2'h3: st_d.out_raw = ~st_q.out_raw;
          default: st_d.out_raw = st_q.out_raw;
        endcase
      end
    end else if (op == OP_PWM) begin
      case (io)
        2'h0: st_d.out_raw = ~oc;
        2'h1: st_d.out_raw = oc;
        // Active while the count is below the duty; full when duty reaches the period.
        2'h2: st_d.out_raw = (st_d.cnt < st_q.cmp_a) ? oc : ~oc;
        default: begin
          if (a_hit) begin
            st_d.out_raw = ~oc;
          end
        end
      endcase
    end
    st_d.pin = (op == OP_TMR) ? 1'b0 : (st_d.out_raw ^ inv);
    st_d.pin_act = (op != OP_TMR) && (op != OP_CAP);

    // APB register access.
    setup = psel & ~penable;
    access = psel & penable;
    unmapped = 1'b0;
    if (setup) begin
      case (paddr)
        OFS_CTL0: st_d.rdata = word8(st_q.ctl0 & C0_MASK);
        OFS_CTL1: st_d.rdata = word8(st_q.ctl1);
        OFS_CTL2: st_d.rdata = word8({5'h00, st_q.tclr, st_q.vlf});
        OFS_CNT_LO: st_d.rdata = word8(st_q.cnt[7:0]);
        OFS_CNT_HI: st_d.rdata = word8({6'h00, st_q.cnt[9:8]});
        OFS_CMPA_LO: st_d.rdata = word8(st_q.cmp_a[7:0]);
        OFS_CMPA_HI: st_d.rdata = word8({6'h00, st_q.cmp_a[9:8]});
        OFS_CAPB_LO: st_d.rdata = word8(st_q.cap_b[7:0]);
        OFS_CAPB_HI: st_d.rdata = word8({6'h00, st_q.cap_b[9:8]});
        OFS_PER_LO: st_d.rdata = word8(st_q.cmp_p[7:0]);
        OFS_PER_HI: st_d.rdata = word8({6'h00, st_q.cmp_p[9:8]});
        default: begin
          st_d.rdata = 32'h00000000;
          unmapped = 1'b1;
        end
      endcase
      if (!HAS_CAP_B && (paddr == OFS_CTL2 || paddr == OFS_CAPB_LO || paddr == OFS_CAPB_HI)) begin
        st_d.rdata = 32'h00000000;
        unmapped = 1'b1;
      end
      st_d.err = unmapped;
    end
    if (access && pwrite && !st_q.err) begin
      case (paddr)
        OFS_CTL0: st_d.ctl0 = pwdata[7:0] & C0_MASK;
        OFS_CTL1: st_d.ctl1 = pwdata[7:0];
        OFS_CTL2: st_d.tclr = pwdata[C2_TCLR_LSB +: 2];
        OFS_CMPA_LO: st_d.cmp_a = put_lo(st_q.cmp_a, pwdata[7:0]);
        OFS_CMPA_HI: st_d.cmp_a = put_hi(st_q.cmp_a, pwdata[7:0]);
        OFS_CAPB_LO: st_d.cap_b = put_lo(st_q.cap_b, pwdata[7:0]);
        OFS_CAPB_HI: st_d.cap_b = put_hi(st_q.cap_b, pwdata[7:0]);
        OFS_PER_LO: st_d.cmp_p = put_lo(st_q.cmp_p, pwdata[7:0]);
        OFS_PER_HI: st_d.cmp_p = put_hi(st_q.cmp_p, pwdata[7:0]);
        default: st_d.err = st_q.err;
      endcase
    end

    // Capture latches; hardware wins over a software write in the same cycle.
    if (cap_rise) begin
      st_d.vlf = 1'b1;
      if (HAS_CAP_B && st_q.tclr != 2'h0) begin
        st_d.cap_b = st_q.cnt;
      end else begin
        st_d.cmp_a = st_q.cnt;
      end
    end
    if (cap_fall) begin
      st_d.vlf = 1'b0;
      st_d.cmp_a = st_q.cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.ctl0 <= CTL0_RST;
      st_q.ctl1 <= CTL1_RST;
      st_q.tclr <= TCLR_RST;
      st_q.cnt <= VAL_RST;
      st_q.cmp_a <= VAL_RST;
      st_q.cap_b <= VAL_RST;
      st_q.cmp_p <= VAL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = access & st_q.err;
  assign timer_out_pin = st_q.pin;
  assign timer_out_active = st_q.pin_act;
  assign cmp_a_flag = st_q.a_flag;
  assign cmp_p_flag = st_q.p_flag;
endmodule
`default_nettype wire

// File: verification/periodic_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_sva
  import periodic_timer_pkg::*;
#(
  parameter bit HAS_CAP_B = 1'b1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timer outputs.
  input wire logic timer_out_pin,
  input wire logic timer_out_active,
  input wire logic cmp_a_flag,
  input wire logic cmp_p_flag
);
  wire logic wr = psel && penable && pwrite;
  logic [7:0] c1_q;
  logic run_q;
  logic [1:0] s0_q;
  logic [1:0] s1_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      c1_q <= 8'h00;
      run_q <= 1'b0;
      s0_q <= 2'h0;
      s1_q <= 2'h0;
    end else begin
      if (wr && paddr == OFS_CTL1) begin
        c1_q <= pwdata[7:0];
        s1_q <= 2'h0;
      end else if (s1_q != 2'h3) begin
        s1_q <= s1_q + 2'h1;
      end
      if (wr && paddr == OFS_CTL0) begin
        run_q <= pwdata[C0_RUN];
        s0_q <= 2'h0;
      end else if (s0_q != 2'h3) begin
        s0_q <= s0_q + 2'h1;
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; psel && penable && paddr > OFS_PER_HI |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped without error");
  property p_okay; HAS_CAP_B && psel && penable && paddr <= OFS_PER_HI && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_okay: assert property (p_okay) else $error("mapped with error");
  property p_rd_hi; psel && penable && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_a_pulse; cmp_a_flag |=> !cmp_a_flag; endproperty
  a_a_pulse: assert property (p_a_pulse) else $error("A flag too long");
  property p_p_pulse; $rose(cmp_p_flag) |=> !cmp_p_flag; endproperty
  a_p_pulse: assert property (p_p_pulse) else $error("P flag too long");
  property p_tmr; s1_q == 2'h3 && c1_q[7:6] == OP_TMR |-> !timer_out_pin && !timer_out_active; endproperty
  a_tmr: assert property (p_tmr) else $error("pin used in timer mode");
  property p_cap; s1_q == 2'h3 && c1_q[7:6] == OP_CAP |-> !timer_out_active; endproperty
  a_cap: assert property (p_cap) else $error("pin used in capture mode");
  property p_no_p;
    s1_q == 2'h3 && c1_q[C1_CCLR] && (c1_q[7:6] == OP_CMP || c1_q[7:6] == OP_TMR) |-> !cmp_p_flag;
  endproperty
  a_no_p: assert property (p_no_p) else $error("P flag with A clear");
  property p_off; s0_q == 2'h3 && !run_q |-> !cmp_a_flag && !cmp_p_flag; endproperty
  a_off: assert property (p_off) else $error("flag while off");
  property p_on;
    wr && paddr == OFS_CTL0 && pwdata[C0_RUN] && !run_q && s1_q == 2'h3 && c1_q[7:6] == OP_CMP
      |-> ##2 timer_out_pin == (c1_q[C1_OC] ^ c1_q[C1_INV]);
  endproperty
  a_on: assert property (p_on) else $error("initial level wrong");
endmodule
bind periodic_timer periodic_timer_sva #(.HAS_CAP_B(HAS_CAP_B)) i_sva (.sys_clk(sys_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_out_pin(timer_out_pin), .timer_out_active(timer_out_active),
  .cmp_a_flag(cmp_a_flag), .cmp_p_flag(cmp_p_flag));
`default_nettype wire

// File: verification/periodic_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_tb;
  import periodic_timer_pkg::*;
  logic sys_clk, nrst, psel, penable, pwrite, cap_input_pin, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd, d, x;
  logic pready, pslverr, timer_out_pin, timer_out_active, cmp_a_flag, cmp_p_flag, ob;
  logic [3:0] div_q = 4'h0;
  int err_count, checks, na, np, nhi, p1, p2, i, k;
  periodic_timer i_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_pin(div_q[1]), .cap_input_pin(cap_input_pin), .line_cmp_out(1'b0), .high_clk(div_q[1]),
    .sub_clk(div_q[2]), .input_src_field(2'h0), .timer_out_pin(timer_out_pin),
    .timer_out_active(timer_out_active), .cmp_a_flag(cmp_a_flag), .cmp_p_flag(cmp_p_flag));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    div_q <= div_q + 4'h1;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int exp_per(input int c, input int p);
    case (c)
      0, 6, 7: return 4 * p;
      1: return p;
      2: return 64 * p;
      3: return 256 * p;
      default: return 8 * p;
    endcase
  endfunction
  task print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      print_verdict();
    end
  endtask
  task watch(input int n);
    na = 0;
    np = 0;
    nhi = 0;
    p1 = -1;
    p2 = -1;
    for (int j = 0; j < n; j++) begin
      @(posedge sys_clk);
      #1;
      if (cmp_a_flag === 1'b1) na++;
      if (cmp_p_flag === 1'b1) np++;
      if (cmp_p_flag === 1'b1 && p1 >= 0 && p2 < 0) p2 = j;
      if (cmp_p_flag === 1'b1 && p1 < 0) p1 = j;
      if (timer_out_pin === 1'b1 && p1 >= 0 && p2 < 0) nhi++;
    end
  endtask
  task wait_flag(input bit sel);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while ((sel ? cmp_p_flag : cmp_a_flag) !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      err_count++;
      print_verdict();
    end
    @(posedge sys_clk);
    #1;
  endtask
  task cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
    apb(1'b1, OFS_CTL0, 32'h0);
    apb(1'b1, OFS_CTL1, {24'h0, c1});
    apb(1'b1, OFS_CMPA_LO, {24'h0, a[7:0]});
    apb(1'b1, OFS_CMPA_HI, {30'h0, a[9:8]});
    apb(1'b1, OFS_PER_LO, {24'h0, p[7:0]});
    apb(1'b1, OFS_PER_HI, {30'h0, p[9:8]});
    apb(1'b1, OFS_CTL0, {24'h0, c0 | 8'h08});
  endtask
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cap_input_pin = 1'b0;
    err_count = 0;
    checks = 0;
    seed = 32'h00011D9E;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    for (i = 0; i <= 10; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", rd, 32'h0);
      chk("reset error", {31'h0, er}, 32'h0);
    end
    for (i = 3; i <= 10; i++) begin
      d = rnd();
      apb(1'b1, 8'(i * 4), d);
      apb(1'b0, 8'(i * 4), 32'h0);
      x = (i < 5) ? 32'h0 : ((i % 2 == 1) ? (d & 32'hFF) : (d & 32'h3));
      chk("value register", rd, x);
    end
    d = rnd() & 32'hF7;
    apb(1'b1, OFS_CTL0, d);
    apb(1'b0, OFS_CTL0, 32'h0);
    chk("control 0", rd, d & 32'hF0);
    apb(1'b1, 8'h30, 32'hFF);
    chk("unmapped write", {31'h0, er}, 32'h1);
    apb(1'b0, 8'h2C, 32'h0);
    chk("unmapped read", {rd[30:0], er}, 32'h1);
    for (k = 0; k < 8; k++) begin
      cfg({1'b0, 3'(k), 4'h0}, 8'h00, 10'h000, 10'h003);
      watch(1800);
      chk("tick period", 32'(p2 - p1), 32'(exp_per(k, 3)));
      chk("zero A flags", 32'(na), 32'h0);
    end
    cfg(8'h10, 8'h00, 10'h000, 10'h000);
    watch(2200);
    chk("overflow period", 32'(p2 - p1), 32'd1024);
    for (k = 0; k < 8; k++) begin
      x = rnd();
      ob = x[0];
      cfg(8'h10, {2'h0, 2'(k), k[2], ob, 2'h0}, 10'h002, 10'h006);
      wait_flag(1'b0);
      x = {31'h0, ob ^ ((k % 4 == 0) ? k[2] : (k % 4 == 1) ? 1'b0 : (k % 4 == 2) ? 1'b1 : ~k[2])};
      chk("match output", {31'h0, timer_out_pin}, x);
      chk("output used", {31'h0, timer_out_active}, 32'h1);
      wait_flag(1'b1);
      chk("P match output", {31'h0, timer_out_pin}, x);
    end
    cfg(8'h10, 8'h01, 10'h004, 10'h002);
    watch(40);
    chk("P flags", 32'(np), 32'h0);
    chk("A flags", 32'(na > 8), 32'h1);
    for (k = 0; k < 4; k++) begin
      cfg(8'h10, {2'h2, 2'((k == 3) ? 2 : k), 4'h8}, (k == 3) ? 10'd12 : 10'd3, 10'd10);
      watch(40);
      chk("PWM duty", 32'(nhi), (k == 0) ? 32'd0 : (k == 2) ? 32'd3 : 32'd10);
    end
    cfg(8'h10, 8'hB8, 10'h005, 10'h00A);
    @(posedge sys_clk);
    #1;
    chk("pulse start", {31'h0, timer_out_pin}, 32'h1);
    watch(40);
    chk("pulse end", {31'h0, timer_out_pin}, 32'h0);
    cfg(8'h10, 8'hC0, 10'h000, 10'h000);
    apb(1'b1, OFS_CTL0, 32'h98);
    apb(1'b0, OFS_CNT_LO, 32'h0);
    x = rd;
    apb(1'b0, OFS_CNT_LO, 32'h0);
    chk("paused count", rd, x);
    apb(1'b1, OFS_CTL0, 32'h18);
    apb(1'b0, OFS_CNT_LO, 32'h0);
    chk("resumed count", {31'h0, rd !== x}, 32'h1);
    apb(1'b1, OFS_CTL0, 32'h10);
    apb(1'b0, OFS_CNT_LO, 32'h0);
    x = rd;
    apb(1'b0, OFS_CNT_LO, 32'h0);
    chk("off count", rd, x);
    apb(1'b1, OFS_CTL0, 32'h18);
    apb(1'b0, OFS_CNT_LO, 32'h0);
    chk("count cleared", {31'h0, rd < 32'd8}, 32'h1);
    cfg(8'h10, 8'h60, 10'h000, 10'h000);
    apb(1'b1, OFS_CTL2, 32'h6);
    @(posedge sys_clk);
    cap_input_pin <= 1'b1;
    wait_flag(1'b0);
    apb(1'b0, OFS_CTL2, 32'h0);
    chk("rising latch", rd, 32'h7);
    cap_input_pin <= 1'b0;
    wait_flag(1'b0);
    apb(1'b0, OFS_CTL2, 32'h0);
    chk("falling latch", rd, 32'h6);
    print_verdict();
  end
endmodule
`default_nettype wire
